// ===== src/pulse_modulator_consts.svh
/*
  Constants for the pulse modulator control decode: register address,
  field positions, reset value, divider masks and duty settings.
  Assumes it is included by its bare name from files under src/.
*/
// Functional notes
// - Control bits 7..6 pick output rate: clock over 128, 64, 32, 16.
// - Control bits 5..4 set minimum duty: 0, 1/8, 1/4, 3/8.
// - Control bits 1..0 set pulse-skip duty: 1/8, 3/8, 5/8, 15/16.
// - Reset clears the whole control byte to zero.
`ifndef PULSE_MODULATOR_CONSTS_SVH
`define PULSE_MODULATOR_CONSTS_SVH

// ---------------------------------------------------------------------
// Register map
// ---------------------------------------------------------------------
`define CTRL_ADDR 9'h111
`define CTRL_RESET 8'h00
`define RDATA_IDLE 8'h00
`define RATE_HI 7
`define RATE_LO 6
`define FLOOR_HI 5
`define FLOOR_LO 4
`define CEIL_HI 3
`define CEIL_LO 2
`define SKIP_HI 1
`define SKIP_LO 0

// ---------------------------------------------------------------------
// Divider: period mask and half-period bit per rate code
// ---------------------------------------------------------------------
`define CNT_RESET 7'h00
`define CNT_STEP 7'h01
`define MASK_DIV128 7'h7F
`define MASK_DIV64 7'h3F
`define MASK_DIV32 7'h1F
`define MASK_DIV16 7'h0F
`define HALF_DIV128 7'h40
`define HALF_DIV64 7'h20
`define HALF_DIV32 7'h10
`define HALF_DIV16 7'h08

// ---------------------------------------------------------------------
// Duty settings in sixteenths of a period
// ---------------------------------------------------------------------
`define DUTY_ZERO 5'h00
`define FLOOR_C0 5'h00
`define FLOOR_C1 5'h02
`define FLOOR_C2 5'h04
`define FLOOR_C3 5'h06
`define CEIL_C0 5'h08
`define CEIL_C1 5'h0A
`define CEIL_C2 5'h0C
`define CEIL_C3 5'h0E
`define SKIP_C0 5'h02
`define SKIP_C1 5'h06
`define SKIP_C2 5'h0A
`define SKIP_C3 5'h0F

`endif

// ===== src/pulse_modulator_control_decode.sv
/*
  Control register and setting decode for a width / pulse-skip switching
  modulator: one byte written by software yields the output rate, the
  minimum and maximum duty for width mode and the pulse-skip duty.
  Assumes a plain register port whose strobes last one cycle, never
  coincide, and are synchronous to SYS_CLK_IN.
*/
// Design decisions made here: the register address and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "pulse_modulator_consts.svh"

module pulse_modulator_control_decode (
  input wire logic SYS_CLK_IN,
  input wire logic SRST_IN,
  input wire logic [8:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  output logic [1:0] RATE_SEL_OUT,
  output logic RATE_CLK_OUT,
  output logic RATE_TICK_OUT,
  output logic [4:0] DUTY_FLOOR_OUT,
  output logic [4:0] DUTY_CEIL_OUT,
  output logic [4:0] SKIP_DUTY_OUT
);

  // ---------------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------------
  pulse_modulator_pkg::ctl_state_t st_r;
  pulse_modulator_pkg::ctl_state_t st_nxt;
  logic ctrl_hit;
  logic [1:0] floor_code;
  logic [1:0] ceil_code;
  logic [1:0] skip_code;
  logic rate_change;

  // Address decode for the one mapped register.
  assign ctrl_hit = (ADDR_IN == `CTRL_ADDR);

  // Field extraction from the stored control byte.
  // Fields come from the stored byte, so settings lag a write by one edge.
  assign floor_code = st_r.ctrl[`FLOOR_HI:`FLOOR_LO];
  assign ceil_code = st_r.ctrl[`CEIL_HI:`CEIL_LO];
  assign skip_code = st_r.ctrl[`SKIP_HI:`SKIP_LO];

  // A new rate restarts the divider so the first period is whole.
  // Without it the divider would finish a period of the old length first,
  // and the downstream modulator would see one runt or stretched cycle.
  assign rate_change = (st_r.rate !=
    pulse_modulator_pkg::rate_sel_t'(st_r.ctrl[`RATE_HI:`RATE_LO]));

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  // Stores writes, answers reads one cycle later and decodes the fields.
  // Read data falls back to zero after one cycle so a stale byte is never
  // taken for a fresh answer; reset wins over a write in the same cycle.
  always_comb begin
    st_nxt = st_r;
    st_nxt.rdata = `RDATA_IDLE;
    if (WR_IN && ctrl_hit) begin
      st_nxt.ctrl = WDATA_IN;
    end
    if (RD_IN && ctrl_hit) begin
      st_nxt.rdata = st_r.ctrl;
    end
    st_nxt.rate =
      pulse_modulator_pkg::rate_sel_t'(st_r.ctrl[`RATE_HI:`RATE_LO]);
    case (floor_code)
      2'b00: st_nxt.floor_duty = `FLOOR_C0;
      2'b01: st_nxt.floor_duty = `FLOOR_C1;
      2'b10: st_nxt.floor_duty = `FLOOR_C2;
      2'b11: st_nxt.floor_duty = `FLOOR_C3;
      default: st_nxt.floor_duty = `DUTY_ZERO;
    endcase
    // Ceiling codes 00 and 11 give one half and seven eighths of a period.
    case (ceil_code)
      2'b00: st_nxt.ceil_duty = `CEIL_C0;
      2'b01: st_nxt.ceil_duty = `CEIL_C1;
      2'b10: st_nxt.ceil_duty = `CEIL_C2;
      2'b11: st_nxt.ceil_duty = `CEIL_C3;
      default: st_nxt.ceil_duty = `CEIL_C0;
    endcase
    case (skip_code)
      2'b00: st_nxt.skip_duty = `SKIP_C0;
      2'b01: st_nxt.skip_duty = `SKIP_C1;
      2'b10: st_nxt.skip_duty = `SKIP_C2;
      2'b11: st_nxt.skip_duty = `SKIP_C3;
      default: st_nxt.skip_duty = `SKIP_C0;
    endcase
    if (SRST_IN) begin
      st_nxt.ctrl = `CTRL_RESET;
      st_nxt.rdata = `RDATA_IDLE;
      st_nxt.rate = pulse_modulator_pkg::RATE_DIV128;
      st_nxt.floor_duty = `FLOOR_C0;
      st_nxt.ceil_duty = `CEIL_C0;
      st_nxt.skip_duty = `SKIP_C0;
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  // Registers the whole control state on every edge.
  always_ff @(posedge SYS_CLK_IN) begin
    st_r <= st_nxt;
  end

  // ---------------------------------------------------------------------
  // Rate divider
  // ---------------------------------------------------------------------
  // Makes the rate clock and the rate tick from the decoded selection.
  // Reset reaches the divider directly, so its outputs clear on the same
  // edge as the control byte.
  rate_divider u_rate_divider (
    .clk_in(SYS_CLK_IN),
    .srst_in(SRST_IN),
    .restart_in(rate_change),
    .rate_in(st_r.rate),
    .rate_clk_out(RATE_CLK_OUT),
    .rate_tick_out(RATE_TICK_OUT)
  );

  // ---------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------
  // Every output is a field of registered state: this block's, or the divider's for the rate clock and tick.
  // Nothing combinational reaches a pin, so downstream timing stays clean.
  assign RDATA_OUT = st_r.rdata;
  assign RATE_SEL_OUT = st_r.rate;
  assign DUTY_FLOOR_OUT = st_r.floor_duty;
  assign DUTY_CEIL_OUT = st_r.ceil_duty;
  assign SKIP_DUTY_OUT = st_r.skip_duty;

  // ---------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------
  // Properties watch the registered outputs; each is disabled in reset
  // unless it checks reset itself.
  // Reset held for two edges leaves the slowest rate and lowest settings one edge on.
  a_reset_clears_ctrl:
    assert property (@(posedge SYS_CLK_IN)
      SRST_IN ##1 SRST_IN |->
        st_r.ctrl == `CTRL_RESET && RATE_SEL_OUT == 2'b00 &&
        DUTY_FLOOR_OUT == `FLOOR_C0 && SKIP_DUTY_OUT == `SKIP_C0)
    else $error("Reset did not clear the control settings.");

  // The rate output follows the top two bits one edge after storage.
  a_rate_sel_follow:
    assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
      1'b1 |=> RATE_SEL_OUT == $past(st_r.ctrl[7:6]))
    else $error("Rate selection does not follow the control byte.");

  // At the fastest rate no tick follows a tick within the next eight cycles.
  a_tick_spacing_fast:
    assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
      RATE_TICK_OUT && RATE_SEL_OUT == 2'b11 && !rate_change |=>
        !RATE_TICK_OUT [*8])
    else $error("Rate tick came early at the fastest rate.");

  // Minimum duty is twice the code in sixteenths.
  a_floor_duty_decode:
    assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
      1'b1 |=> DUTY_FLOOR_OUT == {2'b00, $past(st_r.ctrl[5:4]), 1'b0})
    else $error("Minimum duty does not match its code.");

  // Maximum duty is half a period plus twice the code in sixteenths.
  a_ceil_duty_decode:
    assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
      1'b1 |=> DUTY_CEIL_OUT == {2'b01, $past(st_r.ctrl[3:2]), 1'b0})
    else $error("Maximum duty does not match its code.");

  // Pulse-skip duty takes the four fixed values, one per code.
  a_skip_duty_decode:
    assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
      1'b1 |=> SKIP_DUTY_OUT == (($past(st_r.ctrl[1:0]) == 2'b00) ? 5'h02 :
        ($past(st_r.ctrl[1:0]) == 2'b01) ? 5'h06 :
        ($past(st_r.ctrl[1:0]) == 2'b10) ? 5'h0A : 5'h0F))
    else $error("Pulse-skip duty does not match its code.");

  // A write reaches the decoded rate two edges after its strobe.
  a_write_to_rate:
    assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
      WR_IN && ctrl_hit ##1 !SRST_IN |=>
        RATE_SEL_OUT == $past(WDATA_IN[7:6], 2))
    else $error("Written rate did not reach the output.");

  // A read returns the byte one cycle later and only then.
  a_read_data_window:
    assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
      RD_IN && ctrl_hit |=>
        RDATA_OUT == $past(st_r.ctrl) ##1
        ($past(RD_IN && ctrl_hit) || RDATA_OUT == `RDATA_IDLE))
    else $error("Read data missing or held too long.");

  // Reset clears the read data and the divider outputs one edge on.
  a_reset_clears_outs:
    assert property (@(posedge SYS_CLK_IN)
      SRST_IN |=> RDATA_OUT == `RDATA_IDLE && !RATE_TICK_OUT &&
        !RATE_CLK_OUT && DUTY_CEIL_OUT == `CEIL_C0)
    else $error("Reset did not clear the outputs.");

  // A tick lasts one cycle only.
  a_tick_one_cycle:
    assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
      RATE_TICK_OUT |=> !RATE_TICK_OUT)
    else $error("Rate tick stood longer than one cycle.");

  // A change of rate restarts the divider with both outputs low.
  a_rate_restart:
    assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
      rate_change |=> !RATE_TICK_OUT && !RATE_CLK_OUT)
    else $error("Divider did not restart on a rate change.");

  // At the fastest rate the next tick comes exactly sixteen cycles on.
  a_tick_period_fast:
    assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
      RATE_TICK_OUT && RATE_SEL_OUT == 2'b11 && !rate_change ##1
        !rate_change [*8] ##1 !rate_change [*7] |=> RATE_TICK_OUT)
    else $error("Rate tick period is not sixteen cycles.");

endmodule // pulse_modulator_control_decode

`default_nettype wire

// ===== src/pulse_modulator_pkg.sv
/*
  Types for the pulse modulator control decode.
  Assumes nothing of its surroundings.
*/
package pulse_modulator_pkg;

  // Output rate codes held in the two top control bits.
  typedef enum logic [1:0] {
    RATE_DIV128 = 2'b00,
    RATE_DIV64 = 2'b01,
    RATE_DIV32 = 2'b10,
    RATE_DIV16 = 2'b11
  } rate_sel_t;

  // State of the rate divider.
  typedef struct packed {
    logic [6:0] cnt;
    logic clk;
    logic tick;
  } div_state_t;

  // State of the control decode.
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] rdata;
    rate_sel_t rate;
    logic [4:0] floor_duty;
    logic [4:0] ceil_duty;
    logic [4:0] skip_duty;
  } ctl_state_t;

endpackage

// ===== src/rate_divider.sv
/*
  Divides the system clock by 128, 64, 32 or 16 into a square wave and a
  one-cycle tick at the end of each output period.
  Assumes a synchronous active-high reset and a restart pulse whenever
  the rate selection changes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pulse_modulator_consts.svh"

module rate_divider (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic restart_in,
  input wire pulse_modulator_pkg::rate_sel_t rate_in,
  output logic rate_clk_out,
  output logic rate_tick_out
);

  pulse_modulator_pkg::div_state_t st_r;
  pulse_modulator_pkg::div_state_t st_nxt;
  logic [6:0] mask;
  logic [6:0] half;

  // ---------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------
  // Counts up; a restart clears the count so no runt period follows.
  always_comb begin
    case (rate_in)
      pulse_modulator_pkg::RATE_DIV128: begin
        mask = `MASK_DIV128;
        half = `HALF_DIV128;
      end
      pulse_modulator_pkg::RATE_DIV64: begin
        mask = `MASK_DIV64;
        half = `HALF_DIV64;
      end
      pulse_modulator_pkg::RATE_DIV32: begin
        mask = `MASK_DIV32;
        half = `HALF_DIV32;
      end
      pulse_modulator_pkg::RATE_DIV16: begin
        mask = `MASK_DIV16;
        half = `HALF_DIV16;
      end
      default: begin
        mask = `MASK_DIV128;
        half = `HALF_DIV128;
      end
    endcase
    st_nxt = st_r;
    if (srst_in || restart_in) begin
      st_nxt.cnt = `CNT_RESET;
      st_nxt.clk = 1'b0;
      st_nxt.tick = 1'b0;
    end else begin
      st_nxt.cnt = st_r.cnt + `CNT_STEP;
      st_nxt.clk = |(st_r.cnt & half);
      st_nxt.tick = ((st_r.cnt & mask) == mask);
    end
  end

  // ---------------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------------
  // Registers the whole divider state on every edge.
  always_ff @(posedge clk_in) begin
    st_r <= st_nxt;
  end

  assign rate_clk_out = st_r.clk;
  assign rate_tick_out = st_r.tick;

endmodule // rate_divider

`default_nettype wire

// ===== testbench/pulse_modulator_control_decode_bench.sv
/*
  Self-checking bench for the modulator control decode.
  Assumes the design files under src/ are compiled before this one.
*/
`timescale 1ns/1ps
`default_nettype none

// Compares a value with its expectation and counts the outcome.
`define CHK(got, exp, msg) begin num_checks++; \
  if ((got) !== (exp)) begin fail_count++; \
  $display("ERROR %0t: %s", $time, msg); end end

module pulse_modulator_control_decode_bench;
  // -------------------------------------------------------------------
  // Signals and case table
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [7:0] wdata;
    logic [1:0] rate;
    logic [4:0] floor_d;
    logic [4:0] ceil_d;
    logic [4:0] skip_d;
  } row_t;
  logic clk, srst, wr, rd;
  logic [8:0] addr;
  logic [7:0] wdata, rdata;
  logic [1:0] rate_sel;
  logic rate_clk, rate_tick;
  logic [4:0] floor_d, ceil_d, skip_d;
  int fail_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n, hi;
  row_t rows [6];

  pulse_modulator_control_decode dut (
    .SYS_CLK_IN(clk), .SRST_IN(srst), .ADDR_IN(addr), .WDATA_IN(wdata),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .RATE_SEL_OUT(rate_sel),
    .RATE_CLK_OUT(rate_clk), .RATE_TICK_OUT(rate_tick),
    .DUTY_FLOOR_OUT(floor_d), .DUTY_CEIL_OUT(ceil_d),
    .SKIP_DUTY_OUT(skip_d)
  );

  // Makes the 40 MHz system clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Cuts a hung run short.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("ERROR %0t: timeout", $time);
      finish_test();
    end
  end

  // -------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One-cycle register write.
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // One-cycle read; data must stand one cycle only.
  task automatic rd_check(input logic [8:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, exp, "read data")
    @(posedge clk);
    #1;
    `CHK(rdata, 8'h00, "read data not cleared")
  endtask

  // Checks the four decoded settings against one table row.
  task automatic chk_set(input row_t r);
    `CHK(rate_sel, r.rate, "rate code")
    `CHK(floor_d, r.floor_d, "duty floor")
    `CHK(ceil_d, r.ceil_d, "duty ceiling")
    `CHK(skip_d, r.skip_d, "skip duty")
  endtask

  // Waits for a tick, bounded.
  task automatic wait_tick();
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (rate_tick !== 1'b1 && n < 300);
  endtask

  // -------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------
  initial begin
    srst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 9'h000;
    wdata = 8'h00;
    rows = '{'{8'h00, 2'h0, 5'h00, 5'h08, 5'h02},
             '{8'h55, 2'h1, 5'h02, 5'h0A, 5'h06},
             '{8'hAA, 2'h2, 5'h04, 5'h0C, 5'h0A},
             '{8'hFF, 2'h3, 5'h06, 5'h0E, 5'h0F},
             '{8'h1B, 2'h0, 5'h02, 5'h0C, 5'h0F},
             '{8'hE4, 2'h3, 5'h04, 5'h0A, 5'h02}};
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    // Every code of every field, then read back.
    foreach (rows[i]) begin
      wr_reg(9'h111, rows[i].wdata);
      @(posedge clk);
      #1;
      chk_set(rows[i]);
      rd_check(9'h111, rows[i].wdata);
    end
    // Unmapped places ignore writes and read as zero.
    wr_reg(9'h110, 8'hFF);
    wr_reg(9'h011, 8'hFF);
    @(posedge clk);
    #1;
    chk_set(rows[5]);
    rd_check(9'h110, 8'h00);
    // Output period and high time for each rate code.
    for (int r = 0; r < 4; r++) begin
      wr_reg(9'h111, {2'(r), 6'h00});
      wait_tick();
      wait_tick();
      n = 0;
      hi = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
        if (rate_clk === 1'b1) hi++;
      end while (rate_tick !== 1'b1 && n < 300);
      `CHK(n, 128 >> r, "tick period")
      `CHK(hi, 64 >> r, "rate clock high time")
    end
    // Write then two reads with no gap between the strobes.
    @(posedge clk);
    wr <= 1'b1;
    addr <= 9'h111;
    wdata <= 8'h3C;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(rdata, 8'h3C, "first of two reads")
    `CHK(floor_d, 5'h06, "duty floor after write")
    `CHK(ceil_d, 5'h0E, "duty ceiling after write")
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, 8'h3C, "second of two reads")
    @(posedge clk);
    #1;
    `CHK(rdata, 8'h00, "read data after reads")
    // Reset in mid-run returns every setting to zero code.
    wr_reg(9'h111, 8'hFF);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_set(rows[0]);
    `CHK(rate_clk, 1'b0, "rate clock in reset")
    `CHK(rate_tick, 1'b0, "tick in reset")
    @(posedge clk);
    srst <= 1'b0;
    rd_check(9'h111, 8'h00);
    finish_test();
  end
endmodule // pulse_modulator_control_decode_bench

`default_nettype wire
